// File: rtl/sesi_pkg.sv
// Constants, types and behaviour summary for the serial EEPROM slave block.
// Operation
// RL1 - A data change while the clock is high is a start or stop.
// RL2 - Start is data falling with clock high; nothing counts before a start.
// RL3 - Stop launches the internal write after a write, else back to standby.
// RL4 - First byte is the slave address; type code and chip selects must match.
// RL5 - Address bit one is the top memory address bit; bit zero selects read.
// RL6 - Device pulls data low in the ninth clock of every accepted byte.
// RL7 - Read bytes go out, line released in ninth clock, continue on master ack.
// RL8 - Byte write is address, two address bytes, one data byte, then stop.
// RL9 - No acknowledge of any slave address while the internal write runs.
// RL10 - 512 pages of 256 bytes; upper nine bits pick the page.
// RL11 - Page counter wraps in the page; at most 256 bytes per write.
// RL12 - Write protect sampled before first data byte; high means no ack, reject.
// RL13 - Array starts with every byte at FFh.
// RL14 - Address counter holds the byte after the last one accessed, wrapping.
// RL15 - Read address acked in ninth clock, then byte at counter is sent.
// RL16 - Dummy write loads the counter, repeated start then reads from it.
// RL17 - Sequential read continues while acked and wraps at end of memory.
// RL18 - Master starts a transfer only with the bus idle after a stop.
// RL19 - Data captured on rising clock edges, changed after falling edges.
// RL20 - Write protect is pulled low, so an open pin leaves writes enabled.
// RL21 - Clock and data are synchronised and edge detected before decoding.
// RL22 - Start or stop mid byte abandons the command; unstopped writes vanish. A stop mid data byte here still writes the data bytes acked before it.
package sesi_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_MHZ = 25;
    localparam int WR_TIME_US = 5000;
    localparam int WR_CYCLES = WR_TIME_US * CLK_MHZ;

    // ********************************************************************
    // Memory geometry and reset values
    // ********************************************************************
    localparam int MEM_BYTES = 131072;
    localparam int PAGE_BYTES = 256;
    localparam logic [16:0] ADDR_RESET = 17'h0_0000;
    localparam logic [16:0] ADDR_ONE = 17'h0_0001;
    localparam logic [16:0] WR_CNT_RESET = 17'h0_0000;
    localparam logic [16:0] COMMIT_SPAN = 17'h0_0100;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;

    // ********************************************************************
    // Pins
    // ********************************************************************
    localparam int PIN_COUNT = 5;
    // Idle bus lines read high; straps and protect read low.
    localparam logic [4:0] PIN_IDLE = 5'h03;

    typedef struct packed {
        logic cs_high;
        logic cs_low;
        logic wp;
        logic sda;
        logic scl;
    } sesi_pins_s;

    // ********************************************************************
    // Protocol state and byte phase
    // ********************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_RECV  = 6'h02,
        ST_ACK   = 6'h04,
        ST_SEND  = 6'h08,
        ST_MACK  = 6'h10,
        ST_WRITE = 6'h20
    } sesi_state_e;

    typedef enum logic [3:0] {
        PH_DEV  = 4'h1,
        PH_AHI  = 4'h2,
        PH_ALO  = 4'h4,
        PH_DATA = 4'h8
    } sesi_phase_e;

endpackage

// File: rtl/sesi_pin_sync.sv
// Two-flop synchroniser and edge finder for the serial pins.
`timescale 1ns/100ps
module sesi_pin_sync (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire sesi_pkg::sesi_pins_s pins_i, // Raw pin levels.
    output sesi_pkg::sesi_pins_s level_o, // Synchronised levels.
    output sesi_pkg::sesi_pins_s rise_o, // One-cycle rising pulses.
    output sesi_pkg::sesi_pins_s fall_o // One-cycle falling pulses.
);
    import sesi_pkg::*;

    logic [PIN_COUNT-1:0] raw_w;
    logic [PIN_COUNT-1:0] meta_reg;
    logic [PIN_COUNT-1:0] sync_reg;
    logic [PIN_COUNT-1:0] prev_reg;

    assign raw_w = pins_i;

    // ********************************************************************
    // Per-pin chain
    // ********************************************************************
    // The first stage feeds only the second; edges come from later stages.
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_reg[i] <= PIN_IDLE[i];
                sync_reg[i] <= PIN_IDLE[i];
                prev_reg[i] <= PIN_IDLE[i];
            end else begin
                meta_reg[i] <= raw_w[i]; // RL21
                sync_reg[i] <= meta_reg[i]; // RL21
                prev_reg[i] <= sync_reg[i];
            end
        end
    end

    // Edge pulses compare the settled stage with its one-cycle-old copy.
    assign level_o = sync_reg;
    assign rise_o = sync_reg & ~prev_reg; // RL21
    assign fall_o = ~sync_reg & prev_reg; // RL21

endmodule

// File: rtl/sesi_top.sv
// Serial EEPROM two-wire slave: protocol engine, page buffer and array.
`timescale 1ns/100ps
module sesi_top #(
    parameter int WR_CYCLES_P = sesi_pkg::WR_CYCLES, // Write cycle clocks.
    parameter logic [3:0] DEV_TYPE_CODE = 4'h6 // Type code, value arbitrary.
) (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic scl_i, // Serial clock pin level.
    input wire logic sda_i, // Serial data pin level.
    input wire logic wp_i, // Write protect pin.
    input wire logic chip_select_low_pin, // Chip select strap, low bit.
    input wire logic chip_select_high_pin, // Chip select strap, high bit.
    output logic sda_o, // Data drive value, always low.
    output logic sda_oe, // High while pulling data low.
    output logic write_busy // High during the internal write.
);
    import sesi_pkg::*;

    // ********************************************************************
    // Pin synchronisation
    // ********************************************************************
    sesi_pins_s pins_raw, pins_lvl;
    sesi_pins_s pins_rise, pins_fall;

    assign pins_raw = {chip_select_high_pin, chip_select_low_pin, wp_i,
                       sda_i, scl_i};

    sesi_pin_sync i_sesi_pin_sync (
        .clk(clk), .rst_n(rst_n),
        .pins_i(pins_raw), .level_o(pins_lvl),
        .rise_o(pins_rise), .fall_o(pins_fall)
    );

    // ********************************************************************
    // State and storage
    // ********************************************************************
    sesi_state_e state_reg, state_next;
    sesi_phase_e phase_reg, phase_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic oe_reg, oe_next;
    logic rw_reg, rw_next;
    logic top_reg, top_next;
    logic [7:0] ahi_reg, ahi_next;
    logic [16:0] addr_reg, addr_next;
    logic [PAGE_BYTES-1:0] valid_reg, valid_next;
    logic wp_lat_reg, wp_lat_next;
    logic mack_reg, mack_next;
    logic [16:0] wr_cnt_reg, wr_cnt_next;
    logic busy_reg;
    logic sda_o_reg;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];

    // ********************************************************************
    // Decoding
    // ********************************************************************
    // Any data edge with the clock high is framing, never a data bit.
    wire logic start_det_w = pins_fall.sda & pins_lvl.scl; // RL1
    wire logic stop_det_w = pins_rise.sda & pins_lvl.scl; // RL1
    wire logic scl_rise_w = pins_rise.scl;
    wire logic scl_fall_w = pins_fall.scl;
    wire logic busy_w = (state_reg == ST_WRITE);
    wire logic byte_end_w = scl_fall_w & (bit_cnt_reg == BITS_PER_BYTE);
    wire logic dev_match_w = (shift_reg[7:4] == DEV_TYPE_CODE) &&
        (shift_reg[3:2] == {pins_lvl.cs_high, pins_lvl.cs_low}); // RL4
    wire logic [7:0] rd_byte_w = mem[addr_reg];
    // Full-width increment rolls the last byte back to the first.
    wire logic [16:0] addr_inc_w = addr_reg + ADDR_ONE; // RL14 RL17
    // Page counter only touches the low byte, so it wraps in the page.
    wire logic [16:0] page_inc_w =
        {addr_reg[16:8], addr_reg[7:0] + 8'h01}; // RL11
    wire logic data_take_w = (state_reg == ST_RECV) && byte_end_w &&
        (phase_reg == PH_DATA) && !wp_lat_reg && !start_det_w &&
        !stop_det_w;
    wire logic [7:0] commit_idx_w = wr_cnt_reg[7:0];
    wire logic commit_en_w = busy_w && (wr_cnt_reg < COMMIT_SPAN) &&
        valid_reg[commit_idx_w]; // RL11
    wire logic [16:0] commit_addr_w = {addr_reg[16:8], commit_idx_w}; // RL10
    wire logic wr_done_w = (wr_cnt_reg == 17'(WR_CYCLES_P - 1));
    wire sesi_phase_e phase_adv_w = (phase_reg == PH_DEV) ? PH_AHI :
        ((phase_reg == PH_AHI) ? PH_ALO : PH_DATA);

    // ********************************************************************
    // Protocol next state
    // ********************************************************************
    // Priority: write cycle, then stop, then start, then bit timing.
    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        top_next = top_reg;
        ahi_next = ahi_reg;
        addr_next = addr_reg;
        valid_next = valid_reg;
        wp_lat_next = wp_lat_reg;
        mack_next = mack_reg;
        wr_cnt_next = wr_cnt_reg;
        if (busy_w) begin
            // Bus traffic is ignored, so every address goes unanswered.
            oe_next = 1'b0; // RL9
            wr_cnt_next = wr_cnt_reg + ADDR_ONE;
            if (wr_done_w) begin
                state_next = ST_IDLE;
                valid_next = '0;
            end
        end else if (stop_det_w) begin
            // Only bytes that reached a stop are ever committed.
            oe_next = 1'b0;
            wr_cnt_next = WR_CNT_RESET;
            state_next = (|valid_reg) ? ST_WRITE : ST_IDLE; // RL3 RL8 RL22
        end else if (start_det_w) begin
            // A fresh start drops a half-built write but keeps the counter.
            state_next = ST_RECV; // RL2 RL16
            phase_next = PH_DEV;
            bit_cnt_next = BIT_CNT_RESET;
            oe_next = 1'b0;
            valid_next = '0; // RL22
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_WRITE: ; // Nothing moves until a start.
                ST_RECV: begin
                    if (scl_rise_w && bit_cnt_reg != BITS_PER_BYTE) begin
                        shift_next = {shift_reg[6:0], pins_lvl.sda}; // RL19
                        bit_cnt_next = bit_cnt_reg + BIT_CNT_ONE;
                    end else if (byte_end_w) begin
                        unique case (phase_reg)
                            PH_DEV: begin
                                if (dev_match_w) begin // RL4
                                    top_next = shift_reg[1]; // RL5
                                    rw_next = shift_reg[0]; // RL5
                                    oe_next = 1'b1; // RL6
                                    state_next = ST_ACK;
                                end else begin
                                    state_next = ST_IDLE;
                                end
                            end
                            PH_AHI: begin
                                ahi_next = shift_reg;
                                oe_next = 1'b1; // RL6
                                state_next = ST_ACK;
                            end
                            PH_ALO: begin
                                addr_next = {top_reg, ahi_reg, shift_reg};
                                oe_next = 1'b1; // RL6 RL8
                                state_next = ST_ACK;
                            end
                            PH_DATA: begin
                                if (wp_lat_reg) begin
                                    // Protected: no ack, write thrown away.
                                    state_next = ST_IDLE; // RL12
                                    valid_next = '0; // RL12
                                end else begin
                                    valid_next[addr_reg[7:0]] = 1'b1;
                                    addr_next = page_inc_w; // RL11
                                    oe_next = 1'b1; // RL6 RL8
                                    state_next = ST_ACK;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall_w) begin
                        if (phase_reg == PH_DEV && rw_reg) begin
                            shift_next = rd_byte_w; // RL15
                            oe_next = ~rd_byte_w[7]; // RL15 RL19
                            bit_cnt_next = BIT_CNT_ONE;
                            state_next = ST_SEND;
                        end else begin
                            oe_next = 1'b0;
                            bit_cnt_next = BIT_CNT_RESET;
                            phase_next = phase_adv_w;
                            state_next = ST_RECV;
                            if (phase_reg == PH_ALO) begin
                                // Pin is pulled low outside, so open means 0.
                                wp_lat_next = pins_lvl.wp; // RL12 RL20
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall_w) begin
                        if (bit_cnt_reg == BITS_PER_BYTE) begin
                            oe_next = 1'b0; // RL7
                            state_next = ST_MACK;
                            addr_next = addr_inc_w; // RL14 RL17
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6]; // RL19
                            bit_cnt_next = bit_cnt_reg + BIT_CNT_ONE;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise_w) begin
                        mack_next = ~pins_lvl.sda; // RL7
                    end
                    if (scl_fall_w) begin
                        if (mack_reg) begin
                            shift_next = rd_byte_w; // RL17
                            oe_next = ~rd_byte_w[7];
                            bit_cnt_next = BIT_CNT_ONE;
                            state_next = ST_SEND;
                        end else begin
                            state_next = ST_IDLE; // RL7
                        end
                    end
                end
            endcase
        end
    end

    // ********************************************************************
    // Protocol registers
    // ********************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            phase_reg <= PH_DEV;
            shift_reg <= BYTE_ZERO;
            bit_cnt_reg <= BIT_CNT_RESET;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            top_reg <= 1'b0;
            ahi_reg <= BYTE_ZERO;
            addr_reg <= ADDR_RESET;
            valid_reg <= '0;
            wp_lat_reg <= 1'b0;
            mack_reg <= 1'b0;
            wr_cnt_reg <= WR_CNT_RESET;
            busy_reg <= 1'b0;
            sda_o_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            top_reg <= top_next;
            ahi_reg <= ahi_next;
            addr_reg <= addr_next;
            valid_reg <= valid_next;
            wp_lat_reg <= wp_lat_next;
            mack_reg <= mack_next;
            wr_cnt_reg <= wr_cnt_next;
            busy_reg <= (state_next == ST_WRITE);
            sda_o_reg <= 1'b0;
        end
    end

    // The pin is open drain, so the driven value never leaves low.
    assign sda_o = sda_o_reg;
    assign sda_oe = oe_reg;
    assign write_busy = busy_reg;

    // ********************************************************************
    // Page buffer and array
    // ********************************************************************
    // Buffered bytes reach the array one per clock, early in the write
    // cycle. Plain always, because the erased preset also writes the array.
    always @(posedge clk) begin
        if (data_take_w) begin
            page_buf[addr_reg[7:0]] <= shift_reg; // RL11
        end
        if (commit_en_w) begin
            mem[commit_addr_w] <= page_buf[commit_idx_w]; // RL10
        end
    end

    // Model of the erased array; a real cell array replaces this.
    initial begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] = ERASED_BYTE; // RL13
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_START_ARMS: assert property ( // RL2
        start_det_w && !busy_w && !stop_det_w |=>
        state_reg == ST_RECV && phase_reg == PH_DEV && !sda_oe)
        else $error("start did not arm address reception");
    AST_IDLE_QUIET: assert property ( // RL2
        state_reg == ST_IDLE |-> !sda_oe)
        else $error("data line driven while idle");
    AST_STOP_LAUNCH: assert property ( // RL3
        stop_det_w && !busy_w && (|valid_reg) |=> write_busy)
        else $error("stop after data did not start write cycle");
    AST_BUSY_SILENT: assert property ( // RL9
        busy_w |=> !sda_oe)
        else $error("acknowledge given during internal write");
    AST_ADDR_MISMATCH: assert property ( // RL4
        state_reg == ST_RECV && phase_reg == PH_DEV && byte_end_w &&
        !dev_match_w && !start_det_w && !stop_det_w |=>
        state_reg == ST_IDLE && !sda_oe)
        else $error("foreign address was answered");
    AST_ACK_NINTH: assert property ( // RL6
        state_reg == ST_ACK && !scl_fall_w && !start_det_w && !stop_det_w
        |=> state_reg == ST_ACK && sda_oe)
        else $error("acknowledge not held through ninth clock");
    AST_WP_REJECT: assert property ( // RL12
        state_reg == ST_RECV && phase_reg == PH_DATA && byte_end_w &&
        wp_lat_reg && !start_det_w && !stop_det_w |=>
        state_reg == ST_IDLE && !sda_oe && valid_reg == '0)
        else $error("protected write was accepted");
    AST_READ_WRAP: assert property ( // RL17
        state_reg == ST_SEND && scl_fall_w && !start_det_w &&
        !stop_det_w && bit_cnt_reg == BITS_PER_BYTE |=>
        addr_reg == $past(addr_reg) + ADDR_ONE)
        else $error("read counter did not advance");
    AST_PAGE_WRAP: assert property ( // RL11
        data_take_w |=> addr_reg[16:8] == $past(addr_reg[16:8]) &&
        addr_reg[7:0] == $past(addr_reg[7:0]) + 8'h01)
        else $error("page counter left its page");
    AST_WRITE_HOLDS: assert property ( // RL3
        $rose(write_busy) |-> write_busy [*8])
        else $error("write cycle ended too early");
    COV_BYTE_WRITE: cover property (
        data_take_w ##[1:1000] $rose(write_busy));
    COV_READ_BYTE: cover property (
        state_reg == ST_SEND ##[1:1000] state_reg == ST_MACK);
    COV_SEQ_READ: cover property (
        state_reg == ST_MACK && mack_reg && scl_fall_w);
    COV_WP_REJECT: cover property (
        byte_end_w && phase_reg == PH_DATA && wp_lat_reg);

endmodule

// File: dv/sesi_mst.sv
// Behavioural two-wire bus master that drives the slave's serial pins.
`timescale 1ns/100ps
module sesi_mst (
    input wire logic clk, // System clock; pins move on its falling edge.
    input wire logic sda_in, // Resolved data wire.
    output logic scl, // Serial clock, high when idle.
    output logic pull // High while the master pulls data low.
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Waits n clocks; a bit takes nine so the slave's sync pipe has margin.
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data falls with the clock high; also serves as a repeated start.
    task automatic start();
        pull = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        pull = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask
    // Data rises with the clock high, then the bus rests before reuse.
    task automatic stop();
        pull = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        pull = 1'b0;
        tick(8);
    endtask
    // Leaves idle without a start, for traffic the slave must ignore.
    task automatic idle_low();
        scl = 1'b0;
        tick(1);
    endtask
    // Data moves only while the clock is low; read at the end of high.
    task automatic bit_io(input logic b, output logic r);
        pull = !b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_in;
        scl = 1'b0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // A low ninth bit asks for more; a release ends the read.
    task automatic rd(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask
endmodule

// File: dv/sesi_top_bench.sv
// Self-checking bench for the serial EEPROM slave top.
`timescale 1ns/100ps
module sesi_top_bench;
    import sesi_pkg::*;
    localparam int WR_N = 400; // Short write cycle, still above 256.
    localparam logic [3:0] TYPE = 4'h6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp = 1'b0; // Pull-down level, so writes are enabled.
    logic cs_lo = 1'b1;
    logic cs_hi = 1'b0;
    logic scl, pull, sda_o, sda_oe, busy, ack;
    logic [7:0] rb;
    int err_total = 0;
    int n_compared = 0;
    // Pull-up holds the wire high unless a party pulls it low.
    wire sda_wire = !(pull || (sda_oe && !sda_o));
    always #20 clk = ~clk;
    sesi_top #(.WR_CYCLES_P(WR_N), .DEV_TYPE_CODE(TYPE)) i_sesi_top (
        .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire),
        .wp_i(wp), .chip_select_low_pin(cs_lo),
        .chip_select_high_pin(cs_hi), .sda_o(sda_o), .sda_oe(sda_oe),
        .write_busy(busy));
    sesi_mst i_sesi_mst (.clk(clk), .sda_in(sda_wire), .scl(scl),
        .pull(pull));
    task automatic cmp_bit(input logic got, input logic exp, string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t: %s got %b", $time, m, got);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t: byte %h not %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dev(input logic top, input logic rd);
        return {TYPE, cs_hi, cs_lo, top, rd};
    endfunction
    // Opens a write and loads the address counter.
    task automatic setaddr(input logic [16:0] a);
        i_sesi_mst.start();
        i_sesi_mst.wr(dev(a[16], 1'b0), ack);
        cmp_bit(ack, 1'b1, "addr");
        i_sesi_mst.wr(a[15:8], ack);
        cmp_bit(ack, 1'b1, "hi");
        i_sesi_mst.wr(a[7:0], ack);
        cmp_bit(ack, 1'b1, "lo");
    endtask
    task automatic sel(input logic [16:0] a);
        setaddr(a);
        i_sesi_mst.start();
        i_sesi_mst.wr(dev(a[16], 1'b1), ack);
        cmp_bit(ack, 1'b1, "read");
    endtask
    // Two bytes in sequence, closed by no acknowledge and a stop.
    task automatic rd2(input logic [16:0] a, input logic [7:0] e0, e1);
        sel(a);
        i_sesi_mst.rd(1'b1, rb);
        cmp_byte(rb, e0);
        i_sesi_mst.rd(1'b0, rb);
        cmp_byte(rb, e1);
        i_sesi_mst.stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < WR_N + 20 && busy; i++) @(negedge clk);
        cmp_bit(busy, 1'b0, "busy end");
    endtask
    task automatic t_write();
        setaddr(17'h0_0000);
        i_sesi_mst.wr(8'h5C, ack);
        cmp_bit(ack, 1'b1, "data");
        i_sesi_mst.stop();
        cmp_bit(busy, 1'b1, "busy");
        i_sesi_mst.start();
        i_sesi_mst.wr(dev(1'b0, 1'b1), ack);
        cmp_bit(ack, 1'b0, "poll");
        i_sesi_mst.stop();
        wait_idle();
        rd2(17'h1_FFFF, 8'hFF, 8'h5C);
        $display("t_write done");
    endtask
    task automatic t_refuse();
        i_sesi_mst.idle_low();
        i_sesi_mst.wr(dev(1'b0, 1'b0), ack);
        cmp_bit(ack, 1'b0, "no start");
        i_sesi_mst.stop();
        i_sesi_mst.start();
        i_sesi_mst.wr({TYPE, cs_hi, !cs_lo, 2'b00}, ack);
        cmp_bit(ack, 1'b0, "strap");
        i_sesi_mst.start();
        i_sesi_mst.wr({~TYPE, cs_hi, cs_lo, 2'b00}, ack);
        cmp_bit(ack, 1'b0, "type");
        i_sesi_mst.stop();
        $display("t_refuse done");
    endtask
    // Protected write, then a write abandoned by a repeated start.
    task automatic t_protect();
        wp = 1'b1;
        setaddr(17'h0_1234);
        i_sesi_mst.wr(8'h11, ack);
        cmp_bit(ack, 1'b0, "wp");
        wp = 1'b0;
        i_sesi_mst.stop();
        cmp_bit(busy, 1'b0, "rejected");
        setaddr(17'h0_0040);
        i_sesi_mst.wr(8'h77, ack);
        i_sesi_mst.start();
        i_sesi_mst.stop();
        cmp_bit(busy, 1'b0, "abandoned");
        rd2(17'h0_1234, 8'hFF, 8'hFF);
        rd2(17'h0_003F, 8'hFF, 8'hFF);
        $display("t_protect done");
    endtask
    // Page write wraps in page; reads check the wrapped bytes; counter persists.
    task automatic t_page();
        setaddr(17'h1_02FE);
        for (int i = 0; i < 4; i++) begin
            i_sesi_mst.wr(8'hA1 + 8'(i), ack);
            cmp_bit(ack, 1'b1, "page");
        end
        i_sesi_mst.stop();
        wait_idle();
        rd2(17'h1_0200, 8'hA3, 8'hA4);
        sel(17'h1_02FE);
        i_sesi_mst.rd(1'b0, rb);
        cmp_byte(rb, 8'hA1);
        i_sesi_mst.stop();
        i_sesi_mst.start();
        i_sesi_mst.wr(dev(1'b1, 1'b1), ack);
        cmp_bit(ack, 1'b1, "immediate");
        i_sesi_mst.rd(1'b0, rb);
        cmp_byte(rb, 8'hA2);
        i_sesi_mst.stop();
        $display("t_page done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_write();
        t_refuse();
        t_protect();
        t_page();
        test_done();
    end
    // The run needs about 6000 clocks; cut a hang well beyond that.
    initial begin
        #1_000_000;
        err_total++;
        test_done();
    end
endmodule
